// file: hdl/ssp_dev.sv
// ssp_dev: status register and write protection of a serial eeprom slave.
// assumes link pins come from another domain and are resynchronised here; array storage is outside.
// What this block does
// - falling chip select starts and enables a frame
// - rising chip select ends frame or starts programming
// - serial output released while chip select high
// - sample on rising sck, shift out on falling
// - pin low and arm set block protect changes
// - hold low freezes sequence; master changes hold low-sck
// - hold tied high never suspends
// - status read-only when protected or latch clear
// - bit 0 busy; only status read accepted
// - latch clear blocks every status or array change
// - latch cleared at power-up
// - bits 2,3 block guard, reset zero
// - bits 4 to 6 not retained, read zero
// - bit 7 arms protection; array never blocked
// - arm cannot drop while pin low
// - all status bits read one while programming
// - master reads status twice after programming
// - master may wait 5 ms instead
// - guard bits select protected array range
// - set-latch command sets latch before changes
// - clear-latch, array-write, unprotected status-write clear latch
// - status write ignored unless latch set, unprotected
// - status read allowed busy, repeats byte
`timescale 1ns/10ps
module ssp_dev
	import ssp_pkg::*;
#(
	parameter int unsigned WRITE_CYC = WRITE_CYCLE_CYC
) (
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// serial link
	ssp_link_if.dev          link,
	// user side
	output logic [7:0]       status_view,
	output logic             busy,
	output logic             arr_wr_go,
	output logic [13:0]      arr_wr_addr
);

	typedef enum logic [7:0] {
		D_IDLE = 8'h01,
		D_OPC  = 8'h02,
		D_SET  = 8'h04,
		D_CLR  = 8'h08,
		D_RDS  = 8'h10,
		D_WRS  = 8'h20,
		D_ARW  = 8'h40,
		D_SKIP = 8'h80
	} ssp_dst_e;

	typedef struct packed {
		logic [2:0]  sck_s;
		logic [2:0]  cs_s;
		logic [1:0]  si_s;
		logic [1:0]  hold_s;
		logic [1:0]  wp_s;
		ssp_dst_e    st;
		logic [7:0]  sh;
		logic [7:0]  osh;
		logic [4:0]  cnt;
		logic [15:0] addr;
		logic        latch;
		logic        arm;
		logic        bg_hi;
		logic        bg_lo;
		logic [7:0]  pend;
		logic        pend_st;
		logic        busy;
		logic [15:0] tmr;
		logic        so;
		logic        so_oe;
		logic        wr_go;
		logic [13:0] wr_addr;
		logic [7:0]  view;
	} ssp_dev_s;

	ssp_dev_s q;
	ssp_dev_s d;

	logic        run;
	logic        rise;
	logic        fall;
	logic        cs_up;
	logic        hwp;
	logic        guarded;
	logic [7:0]  stat;
	logic [7:0]  nb;

	always_comb begin
		d = q;
		d.wr_go = 1'b0;
		// resynchronise every pin; first stage feeds only the second
		d.sck_s  = {q.sck_s[1], q.sck_s[0], link.sck};
		d.cs_s   = {q.cs_s[1], q.cs_s[0], link.cs_n};
		d.si_s   = {q.si_s[0], link.si};
		d.hold_s = {q.hold_s[0], link.hold_n};
		d.wp_s   = {q.wp_s[0], link.wp_n};

		run   = q.hold_s[1];
		rise  = run & q.sck_s[1] & ~q.sck_s[2];
		fall  = run & ~q.sck_s[1] & q.sck_s[2];
		cs_up = q.cs_s[1] & ~q.cs_s[2];
		hwp   = ~q.wp_s[1] & q.arm;
		nb    = {q.sh[6:0], q.si_s[1]};

		unique case ({q.bg_hi, q.bg_lo})
			2'b00: guarded = 1'b0;
			2'b01: guarded = q.addr[13:0] >= GUARD_QTR_BASE;
			2'b10: guarded = q.addr[13:0] >= GUARD_HALF_BASE;
			2'b11: guarded = 1'b1;
		endcase

		stat = 8'h00;
		stat[SB_BUSY]  = 1'b0;
		stat[SB_LATCH] = q.latch;
		stat[SB_BG_LO] = q.bg_lo;
		stat[SB_BG_HI] = q.bg_hi;
		stat[SB_ARM]   = q.arm;
		if (q.busy) begin
			stat = STAT_BUSY_VIEW;
		end

		// programming cycle; stored status changes only at its end
		if (q.busy) begin
			if (q.tmr <= 16'h0001) begin
				d.busy = 1'b0;
				if (q.pend_st) begin
					d.arm     = q.pend[SB_ARM];
					d.bg_hi   = q.pend[SB_BG_HI];
					d.bg_lo   = q.pend[SB_BG_LO];
					d.pend_st = 1'b0;
				end
			end else begin
				d.tmr = q.tmr - 16'h0001;
			end
		end

		if (q.cs_s[1]) begin
			if (cs_up) begin
				unique case (q.st)
					D_SET: d.latch = 1'b1;
					D_CLR: d.latch = 1'b0;
					D_WRS: begin
						if (q.cnt >= ST_WR_BITS && q.latch && !hwp) begin
							d.pend    = q.sh;
							d.pend_st = 1'b1;
							d.busy    = 1'b1;
							d.tmr     = 16'(WRITE_CYC);
							d.latch   = 1'b0;
						end
					end
					D_ARW: begin
						if (q.cnt >= ARR_WR_BITS && q.latch) begin
							d.latch = 1'b0;
							if (!guarded) begin
								d.busy    = 1'b1;
								d.pend_st = 1'b0;
								d.tmr     = 16'(WRITE_CYC);
								d.wr_go   = 1'b1;
								d.wr_addr = q.addr[13:0];
							end
						end
					end
					default: ;
				endcase
			end
			d.st = D_IDLE;
		end else begin
			if (q.st == D_IDLE) begin
				d.st  = D_OPC;
				d.cnt = 5'h00;
				d.sh  = 8'h00;
			end
			if (rise) begin
				unique case (q.st)
					D_OPC: begin
						d.sh = nb;
						if (q.cnt == 5'h07) begin
							d.cnt = 5'h00;
							d.st  = D_SKIP;
							if (nb[7:4] == OPC_HI_NIB) begin
								if (nb[2:0] == OPC_ST_RD) begin
									d.st  = D_RDS;
									d.osh = stat;
								end else if (!q.busy) begin
									unique case (nb[2:0])
										OPC_SET_LAT: d.st = D_SET;
										OPC_CLR_LAT: d.st = D_CLR;
										OPC_ST_WR:   d.st = D_WRS;
										OPC_ARR_WR:  d.st = D_ARW;
										default:     d.st = D_SKIP;
									endcase
								end
							end
						end else begin
							d.cnt = q.cnt + 5'h01;
						end
					end
					D_WRS: begin
						if (q.cnt < ST_WR_BITS) begin
							d.sh  = nb;
							d.cnt = q.cnt + 5'h01;
						end
					end
					D_ARW: begin
						if (q.cnt < ADDR_BITS) begin
							d.addr = {q.addr[14:0], q.si_s[1]};
						end
						if (q.cnt < ARR_WR_BITS) begin
							d.cnt = q.cnt + 5'h01;
						end
					end
					default: ;
				endcase
			end
			if (fall && q.st == D_RDS) begin
				d.so = q.osh[7];
				if (q.cnt == 5'h07) begin
					d.osh = stat;
					d.cnt = 5'h00;
				end else begin
					d.osh = {q.osh[6:0], 1'b0};
					d.cnt = q.cnt + 5'h01;
				end
			end
		end

		d.so_oe = (d.st == D_RDS) & q.hold_s[1];
		d.view  = stat;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q         <= '0;
			q.sck_s   <= 3'h0;
			q.cs_s    <= 3'h7;
			q.hold_s  <= 2'h3;
			q.wp_s    <= 2'h3;
			q.st      <= D_IDLE;
			q.latch   <= RST_LATCH;
			q.arm     <= RST_ARM;
			q.bg_hi   <= RST_BG;
			q.bg_lo   <= RST_BG;
		end else begin
			q <= d;
		end
	end

	assign link.so     = q.so;
	assign link.so_oe  = q.so_oe;
	assign status_view = q.view;
	assign busy        = q.busy;
	assign arr_wr_go   = q.wr_go;
	assign arr_wr_addr = q.wr_addr;

endmodule : ssp_dev

// file: hdl/ssp_pkg.sv
// ssp_pkg: constants shared by the serial status-protect device end and its master end.
// assumes a 10 MHz system clock on both ends and a byte-oriented serial link, msb first.
package ssp_pkg;

	// system clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned WRITE_CYCLE_US  = 5000;
	localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned HOST_HALF_CYC   = 8;

	// opcode fields: upper nibble zero, bit 3 ignored, low three bits select
	localparam logic [3:0] OPC_HI_NIB  = 4'h0;
	localparam logic [2:0] OPC_SET_LAT = 3'h6;
	localparam logic [2:0] OPC_CLR_LAT = 3'h4;
	localparam logic [2:0] OPC_ST_RD   = 3'h5;
	localparam logic [2:0] OPC_ST_WR   = 3'h1;
	localparam logic [2:0] OPC_ARR_WR  = 3'h2;

	// protect_status_byte bit positions
	localparam int unsigned SB_BUSY  = 0;
	localparam int unsigned SB_LATCH = 1;
	localparam int unsigned SB_BG_LO = 2;
	localparam int unsigned SB_BG_HI = 3;
	localparam int unsigned SB_ARM   = 7;

	// protect_status_byte reset values and the byte read while busy
	localparam logic RST_LATCH = 1'b0;
	localparam logic RST_BG    = 1'b0;
	localparam logic RST_ARM   = 1'b0;
	localparam logic [7:0] STAT_BUSY_VIEW = 8'hff;

	// guarded array ranges (14-bit array address)
	localparam logic [13:0] GUARD_QTR_BASE  = 14'h3000;
	localparam logic [13:0] GUARD_HALF_BASE = 14'h2000;

	// bit counts of a write frame after the opcode
	localparam logic [4:0] ST_WR_BITS  = 5'h08;
	localparam logic [4:0] ARR_WR_BITS = 5'h18;
	localparam logic [4:0] ADDR_BITS   = 5'h10;

	// master end register map
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_TXD  = 2'h1;
	localparam logic [1:0] REG_RXD  = 2'h2;
	localparam logic [1:0] REG_PINS = 2'h3;
	localparam int unsigned CTRL_XB_LO = 8;
	localparam int unsigned CTRL_RD    = 10;
	localparam int unsigned PINS_HOLD  = 0;
	localparam int unsigned PINS_WP    = 1;

endpackage : ssp_pkg

// file: hdl/ssp_link_if.sv
// ssp_link_if: the serial link between master end and device end.
// assumes both ends share the system clock; serial out is modelled with a pull-up when released.
`timescale 1ns/10ps
interface ssp_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic hold_n;
	logic wp_n;
	logic so_line;

	assign so_line = so_oe ? so : 1'b1;

	modport dev (
		input  cs_n,
		input  sck,
		input  si,
		input  hold_n,
		input  wp_n,
		output so,
		output so_oe
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		output hold_n,
		output wp_n,
		input  so_line
	);
endinterface : ssp_link_if

// file: hdl/ssp_host.sv
// ssp_host: serial master end that frames commands to the status-protect device.
// assumes software uses the plain register port; the serial clock is divided from clk.
`timescale 1ns/10ps
module ssp_host
	import ssp_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic [1:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// serial link
	ssp_link_if.host         link
);

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LOW  = 5'h02,
		H_HIGH = 5'h04,
		H_TAIL = 5'h08,
		H_GAP  = 5'h10
	} ssp_hst_e;

	typedef struct packed {
		logic [1:0]  so_s;
		ssp_hst_e    st;
		logic [3:0]  div;
		logic [5:0]  nbits;
		logic [5:0]  bitn;
		logic [31:0] tx;
		logic [23:0] txd;
		logic [7:0]  rx;
		logic        cs_n;
		logic        sck;
		logic        mosi;
		logic        hold_req;
		logic        hold_n;
		logic        wp_n;
		logic [31:0] rdata;
	} ssp_host_s;

	ssp_host_s q;
	ssp_host_s d;

	always_comb begin
		d = q;
		d.so_s  = {q.so_s[0], link.so_line};
		d.rdata = 32'h0000_0000;
		if (q.div != 4'h0) begin
			d.div = q.div - 4'h1;
		end

		if (reg_wr) begin
			unique case (reg_addr)
				REG_TXD:  d.txd = reg_wdata[23:0];
				REG_PINS: begin
					d.hold_req = reg_wdata[PINS_HOLD];
					d.wp_n     = reg_wdata[PINS_WP];
				end
				REG_CTRL: begin
					if (q.st == H_IDLE) begin
						d.tx    = {reg_wdata[7:0], q.txd};
						d.nbits = 6'(8 * (1 + 32'(reg_wdata[CTRL_XB_LO +: 2])
							+ 32'(reg_wdata[CTRL_RD])));
						d.bitn  = 6'h00;
						d.cs_n  = 1'b0;
						d.mosi  = reg_wdata[7];
						d.div   = 4'(HOST_HALF_CYC - 1);
						d.st    = H_LOW;
					end
				end
				default: ;
			endcase
		end

		unique case (q.st)
			H_IDLE: ;
			H_LOW: begin
				if (q.div == 4'h0) begin
					d.sck = 1'b1;
					d.rx  = {q.rx[6:0], q.so_s[1]};
					d.div = 4'(HOST_HALF_CYC - 1);
					d.st  = H_HIGH;
				end
			end
			H_HIGH: begin
				if (q.div == 4'h0) begin
					d.sck  = 1'b0;
					d.bitn = q.bitn + 6'h01;
					d.div  = 4'(HOST_HALF_CYC - 1);
					if (q.bitn + 6'h01 == q.nbits) begin
						d.st = H_TAIL;
					end else begin
						d.tx   = {q.tx[30:0], 1'b0};
						d.mosi = q.tx[30];
						d.st   = H_LOW;
					end
				end
			end
			H_TAIL: begin
				if (q.div == 4'h0) begin
					d.cs_n = 1'b1;
					d.div  = 4'(HOST_HALF_CYC - 1);
					d.st   = H_GAP;
				end
			end
			H_GAP: begin
				if (q.div == 4'h0) begin
					d.st = H_IDLE;
				end
			end
		endcase

		if (d.st != H_HIGH && !d.sck) begin
			d.hold_n = q.hold_req;
		end

		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: d.rdata = {31'h0, q.st != H_IDLE};
				REG_TXD:  d.rdata = {8'h00, q.txd};
				REG_RXD:  d.rdata = {24'h000000, q.rx};
				REG_PINS: d.rdata = {30'h0, q.wp_n, q.hold_req};
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q          <= '0;
			q.so_s     <= 2'h3;
			q.st       <= H_IDLE;
			q.cs_n     <= 1'b1;
			q.hold_req <= 1'b1;
			q.hold_n   <= 1'b1;
			q.wp_n     <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign link.cs_n   = q.cs_n;
	assign link.sck    = q.sck;
	assign link.si     = q.mosi;
	assign link.hold_n = q.hold_n;
	assign link.wp_n   = q.wp_n;
	assign reg_rdata   = q.rdata;

endmodule : ssp_host

// file: tb/ssp_link_properties.sv
// ssp_link_properties: timing checks on the serial link between the two ends.
// assumes one system clock for both ends and a synchronous active-high reset.
`timescale 1ns/10ps
module ssp_link_properties (
	// system
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so_line
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	so_release_a: assert property (cs_n [*4] |-> !so_oe)
		else $error("so driven in standby");
	opcode_quiet_a: assert property ($fell(cs_n) |-> !so_oe [*8])
		else $error("so driven during opcode");
	cs_fall_idle_a: assert property ($fell(cs_n) |-> !sck)
		else $error("frame opened with sck high");
	sck_frame_a: assert property (cs_n |-> !sck)
		else $error("sck moves outside a frame");
	sck_half_a: assert property ($rose(sck) |=> $stable(sck) [*7])
		else $error("sck high phase too short");
	si_steady_a: assert property (sck |-> $stable(si))
		else $error("si moved while sck high");
	so_shift_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
		else $error("so moved while sck high");
	hold_change_a: assert property ($changed(hold_n) |-> !sck)
		else $error("hold moved while sck high");
	cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*3])
		else $error("chip select high gap too short");
	so_stop_a: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
		else $error("so not released after frame");

	cover property ($rose(so_oe));
	cover property ($fell(hold_n));
	cover property (!hold_n && !cs_n);
	cover property ($fell(cs_n) && !wp_n && so_line);
endmodule : ssp_link_properties

// file: tb/ssp_tb_top.sv
// ssp_tb_top: drives the master end through its register port, watches the device end.
// assumes both ends joined by one link interface and a short programming time.
`timescale 1ns/10ps
module ssp_tb_top
	import ssp_pkg::*;
;
	localparam int unsigned WCYC = 1000;
	logic        clk;
	logic        rst;
	logic [1:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [7:0]  status_view;
	logic        busy;
	logic        arr_wr_go;
	logic [13:0] arr_wr_addr;
	logic [31:0] rv;
	int          fail_count = 0;
	int          check_count = 0;
	int          go_count = 0;

	ssp_link_if ssp_link_if_inst ();
	ssp_host ssp_host_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(ssp_link_if_inst));
	ssp_dev #(.WRITE_CYC(WCYC)) ssp_dev_inst (.clk(clk), .rst(rst), .link(ssp_link_if_inst),
		.status_view(status_view), .busy(busy), .arr_wr_go(arr_wr_go),
		.arr_wr_addr(arr_wr_addr));
	ssp_link_properties ssp_link_properties_inst (.clk(clk), .rst(rst),
		.cs_n(ssp_link_if_inst.cs_n), .sck(ssp_link_if_inst.sck), .si(ssp_link_if_inst.si),
		.so(ssp_link_if_inst.so), .so_oe(ssp_link_if_inst.so_oe),
		.hold_n(ssp_link_if_inst.hold_n), .wp_n(ssp_link_if_inst.wp_n),
		.so_line(ssp_link_if_inst.so_line));

	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) if (arr_wr_go === 1'b1) go_count <= go_count + 1;

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// one whole frame, polled until the master end is idle again
	task automatic frame(input logic [7:0] op, input logic [1:0] xb, input logic [23:0] txd);
		int n;
		wr(REG_TXD, 32'(txd));
		wr(REG_CTRL, {21'h000000, (op == 8'h05), xb, op});
		n = 0;
		rv = 32'h00000001;
		while (rv[0] !== 1'b0 && n < 3000) begin
			rd(REG_CTRL, rv);
			n++;
		end
		if (n >= 3000) begin
			fail_count++;
			final_report();
		end
	endtask : frame

	task automatic sread();
		frame(8'h05, 2'h0, 24'h000000);
		rd(REG_RXD, rv);
	endtask : sread

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1200) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 1200) begin
			fail_count++;
			final_report();
		end
		@(posedge clk);
		#1;
	endtask : wait_idle

	initial begin
		rst = 1'b1;
		reg_addr = 2'h0;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("status_view", 32'(status_view), 32'h00);
		chk("busy", 32'(busy), 32'h0);
		sread();
		chk("read status", 32'(rv[7:0]), 32'h00);
		$display("test reset done");

		frame(8'h0e, 2'h0, 24'h000000);
		chk("latch set", 32'(status_view), 32'h02);
		sread();
		chk("read latch", 32'(rv[7:0]), 32'h02);
		frame(8'h04, 2'h0, 24'h000000);
		chk("latch clear", 32'(status_view), 32'h00);
		$display("test latch done");

		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h01, 2'h1, 24'hf40000);
		chk("busy", 32'(busy), 32'h1);
		chk("busy view", 32'(status_view), 32'hff);
		sread();
		chk("busy read", 32'(rv[7:0]), 32'hff);
		frame(8'h06, 2'h0, 24'h000000);
		wait_idle();
		chk("written status", 32'(status_view), 32'h84);
		sread();
		sread();
		chk("second read", 32'(rv[7:0]), 32'h84);
		$display("test status write done");

		wr(REG_PINS, 32'h00000000);
		wr(REG_PINS, 32'h00000001);
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h01, 2'h1, 24'h000000);
		chk("refused busy", 32'(busy), 32'h0);
		chk("refused status", 32'(status_view), 32'h86);
		$display("test protect done");

		frame(8'h04, 2'h0, 24'h000000);
		chk("cleared", 32'(status_view), 32'h84);
		frame(8'h02, 2'h3, 24'h100055);
		chk("locked write", 32'(go_count), 32'h0);
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h02, 2'h3, 24'h300055);
		chk("guarded write", 32'(go_count), 32'h0);
		chk("guarded latch", 32'(status_view), 32'h84);
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h02, 2'h3, 24'h2fff55);
		chk("open write", 32'(go_count), 32'h1);
		chk("write addr", 32'(arr_wr_addr), 32'h2fff);
		wait_idle();
		$display("test array done");

		wr(REG_PINS, 32'h00000003);
		rd(REG_PINS, rv);
		chk("pins", rv, 32'h00000003);
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h01, 2'h1, 24'h000000);
		wait_idle();
		chk("disarmed", 32'(status_view), 32'h00);
		$display("test disarm done");

		// hold low for a whole frame: device must ignore sck and keep so released
		wr(REG_PINS, 32'h00000002);
		frame(8'h06, 2'h0, 24'h000000);
		chk("held latch", 32'(status_view), 32'h00);
		sread();
		chk("held read", 32'(rv[7:0]), 32'hff);
		wr(REG_PINS, 32'h00000003);
		frame(8'h86, 2'h0, 24'h000000);
		chk("bad opcode", 32'(status_view), 32'h00);
		sread();
		chk("resumed read", 32'(rv[7:0]), 32'h00);
		$display("test hold done");

		// guard level two protects the upper half of the array
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h01, 2'h1, 24'h080000);
		wait_idle();
		chk("half guard", 32'(status_view), 32'h08);
		frame(8'h06, 2'h0, 24'h000000);
		frame(8'h02, 2'h3, 24'h200055);
		chk("half write", 32'(go_count), 32'h1);
		chk("half latch", 32'(status_view), 32'h08);
		$display("test half guard done");
		final_report();
	end
endmodule : ssp_tb_top
